//--- common/tia_consts.svh
/*
 Shared constants of the receiver control front end and its bus master.
 Assumes inclusion by bare name from any file that needs the numbers.
*/
`ifndef TIA_CONSTS_SVH
`define TIA_CONSTS_SVH

`define SLAVE_ADDR 7'h0C
`define LAST_REG 8'h14
`define REG_COUNT 21
`define CTRL_REG 8'h00
`define CTRL_SOFT_RESET_BIT 7
`define CTRL_POWER_DOWN_BIT 6
`define CTRL_PARALLEL_BIT 0
`define CTRL_STORE_MASK 8'h41
`define REG_RESET 8'h00
`define CH_STRIDE 6
`define SWING_REG_BASE 1
`define GAIN_REG_BASE 2
`define SWING_LSB 0
`define RATE_LSB 4
`define GAIN_LSB 0
`define SHIFT_LSB 4

`define GAIN_DEFAULT 2'h3
`define GAIN_MINUS4 2'h2
`define GAIN_MINUS8 2'h1
`define SWING_300 4'h8
`define SWING_250 4'h6
`define SWING_500 4'hD
`define RATE_NOMINAL 4'h8
`define RATE_DOWN 4'h7
`define RATE_UP 4'h9
`define SHIFT_NONE 4'h8
`define SHIFT_UP 4'hC
`define SHIFT_DOWN 4'h4

`define CLK_PERIOD_NS 20
`define SCL_PERIOD_NS 4000
`define SCL_QUARTER_CYCLES (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))

`define HOST_TARGET_REG 8'h00
`define HOST_DATA_REG 8'h01
`define HOST_CTRL_REG 8'h02
`define HOST_STATUS_REG 8'h03
`define HOST_RDATA_REG 8'h04
`define HOST_GO_WRITE_BIT 0
`define HOST_GO_READ_BIT 1
`define HOST_GO_ALT_BIT 2

`endif

//--- common/tia_pkg.sv
/*
 Types shared by the control front end and the bus master.
 Assumes nothing of its surroundings.
*/
package tia_pkg;
	typedef enum logic [1:0] {
		PAD_OPEN = 2'h0,
		PAD_LOW = 2'h1,
		PAD_HIGH = 2'h2
	} pad_state_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_ADDR = 4'h1,
		S_ACK_ADDR = 4'h2,
		S_REG = 4'h3,
		S_ACK_REG = 4'h4,
		S_DATA = 4'h5,
		S_ACK_DATA = 4'h6,
		S_READ = 4'h7,
		S_WAIT = 4'h8
	} slave_state_t;

	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_START = 2'h1,
		M_BIT = 2'h2,
		M_STOP = 2'h3
	} master_state_t;
endpackage

//--- common/two_wire_if.sv
/*
 Open-drain two-wire link between the bus master and the device.
 Assumes pull-ups: a line is high unless some enabled driver pulls it low.
*/
interface two_wire_if;
	logic m_scl_o;
	logic m_scl_oe_n;
	logic m_sda_o;
	logic m_sda_oe_n;
	logic d_sda_o;
	logic d_sda_oe_n;
	logic scl;
	logic sda;

	assign scl = m_scl_oe_n | m_scl_o;
	assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);

	modport device (input scl, input sda, output d_sda_o, output d_sda_oe_n);
	modport master (input scl, input sda, output m_scl_o, output m_scl_oe_n,
		output m_sda_o, output m_sda_oe_n);
endinterface

//--- design/tia_control.sv
/*
 Control front end: tri-state pad decode or two-wire slave register file,
 driving per-channel gain, swing, rate and crossing shift codes.
 Assumes pads and link lines are asynchronous to clk.
*/
// Behaviour
// - Pad mode by default, global settings.
// - Serial enable high ignores all pads.
// - Gain pad: default, minus 4, minus 8.
// - Swing pad: 300, 250, 500 mVpp.
// - Rate pad: nominal, down, up 0.4 GHz.
// - Shift pad: none, up, down 12%.
// - Gain field in registers 2, 8, 14, 20.
// - Swing field in registers 1, 7, 13, 19.
// - Rate field shares the swing registers.
// - Shift field shares the gain registers.
// - Device is slave; master clocks, frames.
// - Address 0001100, direction, register, data, stop.
// - Direction 0 writes, 1 reads.
// - Writes update registers; reads return them.
// - Idle while both lines stay high.
// - Data falling, clock high, is START.
// - Data rising, clock high, is STOP.
// - Repeated START restarts address decoding.
// - One data byte per transfer, acknowledged; the bus master NACKs a read byte.
// - Acknowledge holds data low through high.
// - Wrong address leaves data line high.
`include "tia_consts.svh"

module tia_control (
	input wire logic clk,
	input wire logic reset,
	input wire logic serial_control_enable_pad,
	input wire tia_pkg::pad_state_t gain_pad,
	input wire tia_pkg::pad_state_t output_swing_pad,
	input wire tia_pkg::pad_state_t bandwidth_pad,
	input wire tia_pkg::pad_state_t crossing_shift_pad,
	two_wire_if.device link,
	output logic serial_mode,
	output logic power_down,
	output logic [3:0][1:0] gain_code,
	output logic [3:0][3:0] output_swing_field,
	output logic [3:0][3:0] rate_field,
	output logic [3:0][3:0] crossing_shift_field
);

	logic [8:0] pin_meta;
	logic [8:0] pin_sync;
	logic [1:0] line_meta;
	logic [1:0] line_sync;
	logic [1:0] line_prev;
	tia_pkg::slave_state_t state;
	tia_pkg::slave_state_t next_state;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [7:0] reg_ptr;
	logic [7:0] next_ptr;
	logic [7:0] tx;
	logic [7:0] next_tx;
	logic sda_drive;
	logic next_drive;
	logic [7:0] regs [0:`REG_COUNT-1];

	wire [8:0] pin_raw = {serial_control_enable_pad, gain_pad,
		output_swing_pad, bandwidth_pad, crossing_shift_pad};

	// Two flip-flops on every pin, a third stage only for edge finding.
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_meta <= 9'h000;
			pin_sync <= 9'h000;
			line_meta <= 2'h3;
			line_sync <= 2'h3;
			line_prev <= 2'h3;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			line_meta <= {link.scl, link.sda};
			line_sync <= line_meta;
			line_prev <= line_sync;
		end
	end

	wire scl = line_sync[1];
	wire sda = line_sync[0];
	wire scl_rise = scl & ~line_prev[1];
	wire scl_fall = ~scl & line_prev[1];
	wire start_cond = scl & line_prev[1] & line_prev[0] & ~sda;
	wire stop_cond = scl & line_prev[1] & ~line_prev[0] & sda;
	wire byte_done = scl_fall & (cnt == 4'h8);
	wire addr_match = shreg[7:1] == `SLAVE_ADDR;
	wire ptr_valid = reg_ptr <= `LAST_REG;
	wire [7:0] rd_byte = ptr_valid ? regs[reg_ptr[4:0]] : 8'h00;
	wire [7:0] ptr_off = (reg_ptr - 8'h01) % 8'h06;
	wire ptr_in_chan = (reg_ptr >= 8'h01) && ptr_valid;
	wire wr_hit = (state == tia_pkg::S_DATA) && byte_done;
	wire soft_reset = wr_hit && (reg_ptr == `CTRL_REG)
		&& shreg[`CTRL_SOFT_RESET_BIT];
	wire parallel = regs[0][`CTRL_PARALLEL_BIT];

	// Slave sequencer, stepped by edges of the synchronised link lines.
	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_cnt = cnt;
		next_ptr = reg_ptr;
		next_tx = tx;
		next_drive = sda_drive;
		if (stop_cond) begin
			next_state = tia_pkg::S_IDLE;
			next_drive = 1'b0;
		end else if (start_cond) begin
			next_state = tia_pkg::S_ADDR;
			next_cnt = 4'h0;
			next_drive = 1'b0;
		end else begin
			case (state)
				tia_pkg::S_IDLE: begin
					next_drive = 1'b0;
				end
				tia_pkg::S_ADDR, tia_pkg::S_REG, tia_pkg::S_DATA: begin
					if (scl_rise) begin
						next_shreg = {shreg[6:0], sda};
						next_cnt = cnt + 4'h1;
					end else if (byte_done) begin
						next_cnt = 4'h0;
						if (state == tia_pkg::S_ADDR && !addr_match) begin
							next_state = tia_pkg::S_WAIT;
						end else begin
							next_drive = 1'b1;
							if (state == tia_pkg::S_ADDR) begin
								next_state = tia_pkg::S_ACK_ADDR;
							end else if (state == tia_pkg::S_REG) begin
								next_state = tia_pkg::S_ACK_REG;
								next_ptr = shreg;
							end else begin
								next_state = tia_pkg::S_ACK_DATA;
							end
						end
					end
				end
				tia_pkg::S_ACK_ADDR: begin
					if (scl_fall) begin
						if (shreg[0]) begin
							next_state = tia_pkg::S_READ;
							next_tx = rd_byte;
							next_drive = ~rd_byte[7];
						end else begin
							next_state = tia_pkg::S_REG;
							next_drive = 1'b0;
						end
					end
				end
				tia_pkg::S_ACK_REG: begin
					if (scl_fall) begin
						next_state = tia_pkg::S_DATA;
						next_drive = 1'b0;
					end
				end
				tia_pkg::S_ACK_DATA: begin
					if (scl_fall) begin
						next_state = tia_pkg::S_WAIT;
						next_drive = 1'b0;
					end
				end
				tia_pkg::S_READ: begin
					if (scl_fall) begin
						if (cnt == 4'h7) begin
							next_state = tia_pkg::S_WAIT;
							next_drive = 1'b0;
						end else begin
							next_tx = {tx[6:0], 1'b0};
							next_drive = ~tx[6];
							next_cnt = cnt + 4'h1;
						end
					end
				end
				tia_pkg::S_WAIT: begin
					next_drive = 1'b0;
				end
				default: begin
					next_state = tia_pkg::S_IDLE;
					next_drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= tia_pkg::S_IDLE;
			shreg <= 8'h00;
			cnt <= 4'h0;
			reg_ptr <= 8'h00;
			tx <= 8'h00;
			sda_drive <= 1'b0;
		end else begin
			state <= next_state;
			shreg <= next_shreg;
			cnt <= next_cnt;
			reg_ptr <= next_ptr;
			tx <= next_tx;
			sda_drive <= next_drive;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			link.d_sda_o <= 1'b0;
			link.d_sda_oe_n <= 1'b1;
		end else begin
			link.d_sda_o <= 1'b0;
			link.d_sda_oe_n <= ~next_drive;
		end
	end

	// Register file; parallel mode copies a channel write to all channels.
	for (genvar i = 0; i < `REG_COUNT; i++) begin : g_reg
		localparam logic [7:0] INDEX = 8'(i);
		localparam logic [7:0] OFF = 8'((i + 5) % 6);
		wire same_off = (i != 0) && ptr_in_chan && (ptr_off == OFF);
		wire hit = (reg_ptr == INDEX) || (parallel && same_off);
		wire [7:0] wdata = (i == 0) ? (shreg & `CTRL_STORE_MASK) : shreg;
		always_ff @(posedge clk) begin
			if (reset || soft_reset) begin
				regs[i] <= `REG_RESET;
			end else if (wr_hit && hit) begin
				regs[i] <= wdata;
			end
		end
	end

	wire serial_en = pin_sync[8];
	wire [1:0] pad_gain = pin_sync[7:6];
	wire [1:0] pad_swing = pin_sync[5:4];
	wire [1:0] pad_rate = pin_sync[3:2];
	wire [1:0] pad_shift = pin_sync[1:0];

	wire [1:0] gain_from_pad = (pad_gain == tia_pkg::PAD_LOW) ? `GAIN_MINUS4
		: (pad_gain == tia_pkg::PAD_HIGH) ? `GAIN_MINUS8
		: `GAIN_DEFAULT;
	wire [3:0] swing_from_pad = (pad_swing == tia_pkg::PAD_LOW) ? `SWING_250
		: (pad_swing == tia_pkg::PAD_HIGH) ? `SWING_500
		: `SWING_300;
	wire [3:0] rate_from_pad = (pad_rate == tia_pkg::PAD_LOW) ? `RATE_DOWN
		: (pad_rate == tia_pkg::PAD_HIGH) ? `RATE_UP
		: `RATE_NOMINAL;
	wire [3:0] shift_from_pad = (pad_shift == tia_pkg::PAD_LOW) ? `SHIFT_UP
		: (pad_shift == tia_pkg::PAD_HIGH) ? `SHIFT_DOWN
		: `SHIFT_NONE;

	always_ff @(posedge clk) begin
		if (reset) begin
			serial_mode <= 1'b0;
			power_down <= 1'b0;
		end else begin
			serial_mode <= serial_en;
			power_down <= serial_en & regs[0][`CTRL_POWER_DOWN_BIT];
		end
	end

	for (genvar ch = 0; ch < 4; ch++) begin : g_chan
		localparam int SW = `SWING_REG_BASE + `CH_STRIDE * ch;
		localparam int GN = `GAIN_REG_BASE + `CH_STRIDE * ch;
		always_ff @(posedge clk) begin
			if (reset) begin
				gain_code[ch] <= `GAIN_DEFAULT;
				output_swing_field[ch] <= `SWING_300;
				rate_field[ch] <= `RATE_NOMINAL;
				crossing_shift_field[ch] <= `SHIFT_NONE;
			end else if (serial_en) begin
				gain_code[ch] <= regs[GN][`GAIN_LSB +: 2];
				output_swing_field[ch] <= regs[SW][`SWING_LSB +: 4];
				rate_field[ch] <= regs[SW][`RATE_LSB +: 4];
				crossing_shift_field[ch] <= regs[GN][`SHIFT_LSB +: 4];
			end else begin
				gain_code[ch] <= gain_from_pad;
				output_swing_field[ch] <= swing_from_pad;
				rate_field[ch] <= rate_from_pad;
				crossing_shift_field[ch] <= shift_from_pad;
			end
		end
	end

endmodule // tia_control

//--- design/tia_bus_master.sv
/*
 Two-wire bus master that writes or reads one device register per order.
 Assumes a user port: address, write data, strobes, read data a cycle later.
*/
`include "tia_consts.svh"

module tia_bus_master (
	input wire logic clk,
	input wire logic reset,
	two_wire_if.master link,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic cmd_write,
	input wire logic cmd_read,
	output logic [7:0] cmd_rdata
);

	localparam logic [7:0] QUARTER = 8'(`SCL_QUARTER_CYCLES);

	tia_pkg::master_state_t mstate;
	logic [7:0] qcnt;
	logic [1:0] phase;
	logic [3:0] bitcnt;
	logic [1:0] byte_idx;
	logic rd_mode;
	logic alt_addr;
	logic busy;
	logic nack;
	logic ack_bad;
	logic [7:0] target;
	logic [7:0] wdata;
	logic [7:0] rx;
	logic [7:0] rx_data;
	logic [1:0] sda_meta;
	logic sda_in;

	wire tick = busy && (qcnt == QUARTER - 8'h01);
	wire go = cmd_write && (cmd_addr == `HOST_CTRL_REG) && !busy;
	wire [6:0] dev_addr = `SLAVE_ADDR ^ {6'h00, alt_addr};
	wire [7:0] tx_byte = (byte_idx == 2'h0) ? {dev_addr, 1'b0}
		: (byte_idx == 2'h1) ? target
		: (byte_idx == 2'h3) ? 8'hFF
		: rd_mode ? {dev_addr, 1'b1} : wdata;
	wire bit_out = (bitcnt < 4'h8) ? tx_byte[3'(4'h7 - bitcnt)] : 1'b1;
	wire last_byte = (byte_idx == 2'h3) || (byte_idx == 2'h2 && !rd_mode);
	wire [7:0] status = {6'h00, nack, busy};
	wire [7:0] rd_mux = (cmd_addr == `HOST_TARGET_REG) ? target
		: (cmd_addr == `HOST_DATA_REG) ? wdata
		: (cmd_addr == `HOST_STATUS_REG) ? status
		: (cmd_addr == `HOST_RDATA_REG) ? rx_data : 8'h00;

	always_ff @(posedge clk) begin
		if (reset) begin
			sda_meta <= 2'h3;
			sda_in <= 1'b1;
		end else begin
			sda_meta <= {sda_meta[0], link.sda};
			sda_in <= sda_meta[1];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			target <= 8'h00;
			wdata <= 8'h00;
			cmd_rdata <= 8'h00;
		end else begin
			if (cmd_write && cmd_addr == `HOST_TARGET_REG) target <= cmd_wdata;
			if (cmd_write && cmd_addr == `HOST_DATA_REG) wdata <= cmd_wdata;
			cmd_rdata <= cmd_read ? rd_mux : 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !busy || tick) qcnt <= 8'h00;
		else qcnt <= qcnt + 8'h01;
	end

	// Bit engine: four quarter-period phases per START, bit or STOP.
	always_ff @(posedge clk) begin
		if (reset) begin
			mstate <= tia_pkg::M_IDLE;
			phase <= 2'h0;
			bitcnt <= 4'h0;
			byte_idx <= 2'h0;
			rd_mode <= 1'b0;
			alt_addr <= 1'b0;
			busy <= 1'b0;
			nack <= 1'b0;
			ack_bad <= 1'b0;
			rx <= 8'h00;
			rx_data <= 8'h00;
			link.m_scl_o <= 1'b0;
			link.m_sda_o <= 1'b0;
			link.m_scl_oe_n <= 1'b1;
			link.m_sda_oe_n <= 1'b1;
		end else if (go && (cmd_wdata[`HOST_GO_WRITE_BIT]
				|| cmd_wdata[`HOST_GO_READ_BIT])) begin
			busy <= 1'b1;
			nack <= 1'b0;
			rd_mode <= cmd_wdata[`HOST_GO_READ_BIT];
			alt_addr <= cmd_wdata[`HOST_GO_ALT_BIT];
			byte_idx <= 2'h0;
			bitcnt <= 4'h0;
			phase <= 2'h0;
			mstate <= tia_pkg::M_START;
		end else if (tick) begin
			phase <= phase + 2'h1;
			case (mstate)
				tia_pkg::M_START: begin
					case (phase)
						2'h0: link.m_sda_oe_n <= 1'b1;
						2'h1: link.m_scl_oe_n <= 1'b1;
						2'h2: link.m_sda_oe_n <= 1'b0;
						default: begin
							link.m_scl_oe_n <= 1'b0;
							bitcnt <= 4'h0;
							mstate <= tia_pkg::M_BIT;
						end
					endcase
				end
				tia_pkg::M_BIT: begin
					case (phase)
						2'h0: link.m_sda_oe_n <= bit_out;
						2'h1: link.m_scl_oe_n <= 1'b1;
						2'h2: begin
							if (bitcnt < 4'h8) rx <= {rx[6:0], sda_in};
							else ack_bad <= sda_in && (byte_idx != 2'h3);
						end
						default: begin
							link.m_scl_oe_n <= 1'b0;
							if (bitcnt != 4'h8) begin
								bitcnt <= bitcnt + 4'h1;
							end else if (ack_bad) begin
								nack <= 1'b1;
								mstate <= tia_pkg::M_STOP;
							end else if (last_byte) begin
								if (byte_idx == 2'h3) rx_data <= rx;
								mstate <= tia_pkg::M_STOP;
							end else if (byte_idx == 2'h1 && rd_mode) begin
								byte_idx <= 2'h2;
								mstate <= tia_pkg::M_START;
							end else begin
								bitcnt <= 4'h0;
								byte_idx <= byte_idx + 2'h1;
							end
						end
					endcase
				end
				tia_pkg::M_STOP: begin
					case (phase)
						2'h0: link.m_sda_oe_n <= 1'b0;
						2'h1: link.m_scl_oe_n <= 1'b1;
						2'h2: link.m_sda_oe_n <= 1'b1;
						default: begin
							busy <= 1'b0;
							mstate <= tia_pkg::M_IDLE;
						end
					endcase
				end
				default: begin
					busy <= 1'b0;
					mstate <= tia_pkg::M_IDLE;
				end
			endcase
		end
	end

endmodule // tia_bus_master

//--- bench/tia_link_chk.sv
/*
 Checker of the two-wire link between the bus master and the device.
 Assumes instantiation beside the interface in the bench top module.
*/
module tia_link_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic m_scl_o,
	input wire logic m_scl_oe_n,
	input wire logic m_sda_o,
	input wire logic m_sda_oe_n,
	input wire logic d_sda_o,
	input wire logic d_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_dev_open_drain: assert property (d_sda_o == 1'b0)
		else $error("device drives sda high");
	a_mst_open_drain: assert property (!m_scl_o && !m_sda_o)
		else $error("master drives a line high");
	a_reset_release: assert property (disable iff (1'b0)
		$fell(reset) |-> m_scl_oe_n && m_sda_oe_n && d_sda_oe_n)
		else $error("a line is pulled after reset");
	a_dev_scl_low: assert property ($changed(d_sda_oe_n) |-> !scl)
		else $error("device moved sda while scl high");
	a_ack_held: assert property ($rose(scl) && !d_sda_oe_n |->
		(!sda throughout ##[1:150] !scl))
		else $error("acknowledge not held through scl high");
	a_start_clocks: assert property ($fell(sda) && scl |->
		##[1:150] !scl)
		else $error("no clock after start");
	a_stop_idle: assert property ($rose(sda) && scl |->
		(sda && scl) [*8])
		else $error("bus not idle after stop");
	a_ack_delay: assert property ($fell(d_sda_oe_n) |->
		!scl && !$past(scl, 3))
		else $error("device drove sda too soon after scl fall");
endmodule // tia_link_chk

//--- bench/tb_tia_pad_and_two_wire_control.sv
/*
 Self-checking bench: control front end and bus master joined by the link.
 Assumes the host port, pad decode and register layout of the hand-over.
*/
module tb_tia_pad_and_two_wire_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic sel = 1'b0;
	tia_pkg::pad_state_t pad = tia_pkg::PAD_OPEN;
	tia_pkg::pad_state_t pad_swing = tia_pkg::PAD_OPEN;
	tia_pkg::pad_state_t pad_rate = tia_pkg::PAD_OPEN;
	tia_pkg::pad_state_t pad_shift = tia_pkg::PAD_OPEN;
	logic [7:0] cmd_addr = 8'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_write = 1'b0;
	logic cmd_read = 1'b0;
	logic [7:0] cmd_rdata;
	logic serial_mode;
	logic power_down;
	logic [3:0][1:0] gain_code;
	logic [3:0][3:0] swing;
	logic [3:0][3:0] rate;
	logic [3:0][3:0] shift;
	int errors = 0;
	int num_checks = 0;

	two_wire_if link ();

	always #10 clk = ~clk;

	tia_control tia_control_inst (.clk(clk), .reset(reset),
		.serial_control_enable_pad(sel), .gain_pad(pad),
		.output_swing_pad(pad_swing), .bandwidth_pad(pad_rate),
		.crossing_shift_pad(pad_shift), .link(link.device),
		.serial_mode(serial_mode), .power_down(power_down),
		.gain_code(gain_code), .output_swing_field(swing),
		.rate_field(rate), .crossing_shift_field(shift));

	tia_bus_master tia_bus_master_inst (.clk(clk), .reset(reset),
		.link(link.master), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_rdata(cmd_rdata));

	tia_link_chk tia_link_chk_inst (.clk(clk), .reset(reset),
		.m_scl_o(link.m_scl_o), .m_scl_oe_n(link.m_scl_oe_n),
		.m_sda_o(link.m_sda_o), .m_sda_oe_n(link.m_sda_oe_n),
		.d_sda_o(link.d_sda_o), .d_sda_oe_n(link.d_sda_oe_n),
		.scl(link.scl), .sda(link.sda));

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_write <= 1'b1;
		@(posedge clk);
		cmd_write <= 1'b0;
	endtask

	task automatic host_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		cmd_addr <= a;
		cmd_read <= 1'b1;
		@(posedge clk);
		cmd_read <= 1'b0;
		@(negedge clk);
		d = cmd_rdata;
	endtask

	task automatic wait_idle(input logic [7:0] exp);
		logic [7:0] st;
		for (int i = 0; i < 5000; i++) begin
			host_rd(8'h03, st);
			if (st[0] === 1'b0) begin
				check(st, exp);
				return;
			end
		end
		errors++;
		$display("ERROR %0t: link stayed busy", $time);
		close_out();
	endtask

	task automatic dev_wr(input logic [7:0] r, input logic [7:0] d);
		host_wr(8'h00, r);
		host_wr(8'h01, d);
		host_wr(8'h02, 8'h01);
		wait_idle(8'h00);
	endtask

	task automatic dev_rd(input logic [7:0] r, input logic [7:0] exp);
		logic [7:0] d;
		host_wr(8'h00, r);
		host_wr(8'h02, 8'h02);
		wait_idle(8'h00);
		host_rd(8'h04, d);
		check(d, exp);
	endtask

	task automatic test_pads();
		logic [11:0] gt = 12'h123;
		logic [11:0] st = 12'hD68;
		logic [11:0] rt = 12'h978;
		logic [11:0] ht = 12'h4C8;
		int sa;
		int sr;
		int sh;
		for (int s = 0; s < 3; s++) begin
			@(posedge clk);
			sa = (s + 1) % 3;
			sr = (s + 2) % 3;
			sh = (2 * s) % 3;
			pad <= tia_pkg::pad_state_t'(s);
			pad_swing <= tia_pkg::pad_state_t'(sa);
			pad_rate <= tia_pkg::pad_state_t'(sr);
			pad_shift <= tia_pkg::pad_state_t'(sh);
			repeat (4) @(posedge clk);
			@(negedge clk);
			check({7'h00, serial_mode}, 8'h00);
			for (int c = 0; c < 4; c++) begin
				check({6'h00, gain_code[c]}, {4'h0, gt[4*s+:4]});
				check({4'h0, swing[c]}, {4'h0, st[4*sa+:4]});
				check({4'h0, rate[c]}, {4'h0, rt[4*sr+:4]});
				check({4'h0, shift[c]}, {4'h0, ht[4*sh+:4]});
			end
		end
		$display("test_pads done");
	endtask

	task automatic test_serial();
		logic [7:0] e;
		logic [7:0] f;
		@(posedge clk);
		sel <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			dev_wr(8'(6 * c + 1), 8'(8'h35 + 17 * c));
			dev_wr(8'(6 * c + 2), 8'(8'h92 + 17 * c));
		end
		@(posedge clk);
		pad <= tia_pkg::PAD_HIGH;
		pad_swing <= tia_pkg::PAD_HIGH;
		pad_rate <= tia_pkg::PAD_HIGH;
		pad_shift <= tia_pkg::PAD_HIGH;
		repeat (4) @(posedge clk);
		@(negedge clk);
		check({7'h00, serial_mode}, 8'h01);
		for (int c = 0; c < 4; c++) begin
			e = 8'(8'h35 + 17 * c);
			f = 8'(8'h92 + 17 * c);
			check({4'h0, swing[c]}, {4'h0, e[3:0]});
			check({4'h0, rate[c]}, {4'h0, e[7:4]});
			check({6'h00, gain_code[c]}, {6'h00, f[1:0]});
			check({4'h0, shift[c]}, {4'h0, f[7:4]});
		end
		dev_rd(8'h01, 8'h35);
		dev_rd(8'h14, 8'hC5);
		$display("test_serial done");
	endtask

	task automatic test_ctrl();
		logic [7:0] d;
		dev_wr(8'h00, 8'h40);
		check({7'h00, power_down}, 8'h01);
		dev_wr(8'h00, 8'h80);
		check({7'h00, power_down}, 8'h00);
		check({4'h0, swing[0]}, 8'h00);
		check({6'h00, gain_code[3]}, 8'h00);
		host_rd(8'h07, d);
		check(d, 8'h00);
		$display("test_ctrl done");
	endtask

	task automatic test_nack();
		host_wr(8'h00, 8'h01);
		host_wr(8'h01, 8'h00);
		host_wr(8'h02, 8'h05);
		wait_idle(8'h02);
		check({4'h0, swing[0]}, 8'h05);
		check({4'h0, rate[0]}, 8'h03);
		$display("test_nack done");
	endtask

	task automatic test_parallel();
		dev_wr(8'h00, 8'h01);
		dev_wr(8'h08, 8'h5A);
		for (int c = 0; c < 4; c++) begin
			check({6'h00, gain_code[c]}, 8'h02);
			check({4'h0, shift[c]}, 8'h05);
			check({4'h0, swing[c]}, {4'h0, 4'(5 + c)});
		end
		$display("test_parallel done");
	endtask

	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		test_pads();
		test_serial();
		test_nack();
		test_parallel();
		test_ctrl();
		close_out();
	end
endmodule // tb_tia_pad_and_two_wire_control
